/* pkg/wd_pkg.sv */
// Package holding register map, field positions, vectors and timing constants of the watchdog
package wd_pkg;

	// Register offsets on the local register port
	localparam int         ADDR_W           = 4;
	localparam logic [3:0] OFS_CONTROL      = 4'h0;
	localparam logic [3:0] OFS_RESET_STATUS = 4'h1;
	localparam logic [3:0] OFS_IRQ_STATUS   = 4'h2;
	localparam logic [3:0] OFS_IRQ_MASK     = 4'h3;

	// Field positions in watchdog_control_status
	localparam int BIT_IRQ_FLAG  = 7;
	localparam int BIT_IRQ_EN    = 6;
	localparam int BIT_SEL3      = 5;
	localparam int BIT_CHANGE_EN = 4;
	localparam int BIT_RESET_EN  = 3;
	localparam int BIT_SEL2      = 2;
	localparam int BIT_SEL1      = 1;
	localparam int BIT_SEL0      = 0;

	// Field position of the reset flag in mcu_reset_status_reg
	localparam int BIT_RESET_FLAG = 3;

	// Event bits of the interrupt status and mask registers
	localparam int EVT_W     = 2;
	localparam int EVT_IRQ   = 0;
	localparam int EVT_RESET = 1;

	// Reset values
	localparam logic [3:0]       SELECT_RESET = 4'h0;
	localparam logic [EVT_W-1:0] MASK_RESET   = 2'h0;

	// Timing
	localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
	localparam int         OSC_FREQ_KHZ         = 128;
	localparam int         TIMEOUT_BASE_CYCLES  = 2048;
	localparam int         COUNT_W              = 21;
	localparam logic [3:0] MAX_SELECT           = 4'h9;

	// Vector slots
	localparam logic [5:0]  WD_IRQ_VECTOR    = 6'h0d;
	localparam logic [15:0] WD_IRQ_ADDR      = 16'h0018;
	localparam logic [5:0]  SYS_RESET_VECTOR = 6'h01;
	localparam logic [15:0] SYS_RESET_ADDR   = 16'h0000;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_STOPPED   = 2'b00,
		MODE_IRQ       = 2'b01,
		MODE_RESET     = 2'b10,
		MODE_IRQ_RESET = 2'b11
	} mode_t;

	// Register port request
	typedef struct packed {
		logic              write;
		logic              read;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} reg_req_t;

	// Vector slot carried with a request
	typedef struct packed {
		logic [5:0]  number;
		logic [15:0] address;
	} vector_t;

endpackage

/* logic/watchdog_timeout_control.sv */
// Watchdog time-out control: protected control register, time-out counter, interrupt and reset requests
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module watchdog_timeout_control
	import wd_pkg::*;
#(
	parameter int TIMEOUT_BASE = TIMEOUT_BASE_CYCLES,
	parameter int CNT_W        = COUNT_W
)
(
	// Clock, reset and enable
	input  wire logic     clk,
	input  wire logic     rst_b,
	input  wire logic     clk_en,
	// Register port
	input  wire reg_req_t reg_req,
	output logic [7:0]    reg_rdata,
	// Watchdog oscillator and strap
	input  wire logic     wd_osc_clk,
	input  wire logic     always_on_fuse,
	// CPU side
	input  wire logic     wd_restart,
	input  wire logic     irq_vector_ack,
	output logic          wd_irq_req,
	output vector_t       wd_irq_vector,
	output logic          sys_reset_req,
	output vector_t       sys_reset_vector,
	output logic          irq
);

	// Synchronisers and oscillator edge
	logic             osc_s1;
	logic             osc_s2;
	logic             osc_s3;
	logic             fuse_s1;
	logic             fuse_s;
	logic             osc_tick;
	// Control register fields
	logic             wd_irq_flag;
	logic             wd_irq_enable;
	logic             wd_change_enable;
	logic             wd_reset_enable;
	logic [3:0]       timeout_select;
	logic [2:0]       window_left;
	logic             wd_reset_flag;
	// Counter and mode
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] limit;
	logic [3:0]       sel_eff;
	logic             eff_reset_en;
	logic             eff_irq_en;
	mode_t            mode;
	logic             take_irq;
	logic             take_reset;
	logic             timeout_hit;
	// Register decode and interrupt registers
	logic             ctl_wr;
	logic             ctl_rd;
	logic             rst_wr;
	logic             stat_rd;
	logic             mask_wr;
	logic [3:0]       next_select;
	logic [EVT_W-1:0] irq_status;
	logic [EVT_W-1:0] irq_mask;
	logic [EVT_W-1:0] evt_set;

	// Oscillator and fuse pass two flops before anything looks at them
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			osc_s1  <= 1'b0;
			osc_s2  <= 1'b0;
			osc_s3  <= 1'b0;
			fuse_s1 <= 1'b0;
			fuse_s  <= 1'b0;
		end
		else if (clk_en)
		begin
			osc_s1  <= wd_osc_clk;
			osc_s2  <= osc_s1;
			osc_s3  <= osc_s2;
			fuse_s1 <= always_on_fuse;
			fuse_s  <= fuse_s1;
		end
	end

	// One tick per rising oscillator edge; the oscillator must stay well below clk/4
	assign osc_tick = osc_s2 & ~osc_s3;
	// Register decode
	assign ctl_wr  = clk_en & reg_req.write & (reg_req.addr == OFS_CONTROL);
	assign ctl_rd  = clk_en & reg_req.read  & (reg_req.addr == OFS_CONTROL);
	assign rst_wr  = clk_en & reg_req.write & (reg_req.addr == OFS_RESET_STATUS);
	assign stat_rd = clk_en & reg_req.read  & (reg_req.addr == OFS_IRQ_STATUS);
	assign mask_wr = clk_en & reg_req.write & (reg_req.addr == OFS_IRQ_MASK);
	// Select field gathered from the scattered control bits
	assign next_select = {reg_req.wdata[BIT_SEL3], reg_req.wdata[BIT_SEL2],
		reg_req.wdata[BIT_SEL1], reg_req.wdata[BIT_SEL0]};
	// Effective enables: the fuse locks reset on and interrupt off
	assign eff_reset_en = fuse_s | wd_reset_enable | wd_reset_flag;
	assign eff_irq_en   = wd_irq_enable & ~fuse_s;
	assign mode         = mode_t'({eff_reset_en, eff_irq_en});

	// Action chosen for a time-out in each mode
	always_comb
	begin
		take_irq   = 1'b0;
		take_reset = 1'b0;
		case (mode)
			MODE_IRQ:
				take_irq = 1'b1;
			MODE_RESET:
				take_reset = 1'b1;
			MODE_IRQ_RESET:
			begin
				// First time-out interrupts; a flag left pending escalates to reset
				take_irq   = ~wd_irq_flag;
				take_reset = wd_irq_flag;
			end
			default:
			begin
				take_irq   = 1'b0;
				take_reset = 1'b0;
			end
		endcase
	end

	// Reserved codes fall back to the longest length
	assign sel_eff     = (timeout_select > MAX_SELECT) ? MAX_SELECT : timeout_select;
	assign limit       = CNT_W'(TIMEOUT_BASE) << sel_eff;
	assign timeout_hit = clk_en & osc_tick & (mode != MODE_STOPPED) & ~wd_restart
		& (count == limit - CNT_W'(1));

	// Time-out counter in oscillator cycles
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			count <= '0;
		else if (clk_en)
		begin
			// A shorter length must not fire against an old long count
			if (wd_restart || (ctl_wr && wd_change_enable && next_select != timeout_select))
				count <= '0;
			else if (mode == MODE_STOPPED || timeout_hit)
				count <= '0;
			else if (osc_tick)
				count <= count + CNT_W'(1);
		end
	end

	// Change window: opened by a write with change enable set, closed by hardware
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			wd_change_enable <= 1'b0;
			window_left      <= 3'h0;
		end
		else if (clk_en)
		begin
			if (ctl_wr && reg_req.wdata[BIT_CHANGE_EN])
			begin
				wd_change_enable <= 1'b1;
				window_left      <= CHANGE_WINDOW_CYCLES;
			end
			else if (ctl_wr)
			begin
				// The protected write itself uses up the window
				wd_change_enable <= 1'b0;
				window_left      <= 3'h0;
			end
			else if (window_left != 3'h0)
			begin
				window_left      <= window_left - 3'h1;
				wd_change_enable <= (window_left != 3'h1);
			end
		end
	end

	// Reset enable and time-out select are only loosened inside the window
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			wd_reset_enable <= 1'b0;
			timeout_select  <= SELECT_RESET;
		end
		else if (ctl_wr)
		begin
			if (reg_req.wdata[BIT_RESET_EN])
				wd_reset_enable <= 1'b1;
			else if (wd_change_enable)
				wd_reset_enable <= 1'b0;
			if (wd_change_enable)
				timeout_select <= next_select;
		end
	end

	// Interrupt enable; executing the vector in combined mode drops back to reset mode
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wd_irq_enable <= 1'b0;
		else if (clk_en)
		begin
			if (ctl_wr)
				wd_irq_enable <= reg_req.wdata[BIT_IRQ_EN];
			else if (irq_vector_ack && eff_reset_en)
				wd_irq_enable <= 1'b0;
		end
	end

	// Interrupt flag: set wins over both ways of clearing it
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wd_irq_flag <= 1'b0;
		else if (clk_en)
		begin
			if (timeout_hit && take_irq)
				wd_irq_flag <= 1'b1;
			else if (irq_vector_ack || (ctl_wr && reg_req.wdata[BIT_IRQ_FLAG]))
				wd_irq_flag <= 1'b0;
		end
	end

	// Reset flag: set by our own system reset, cleared by writing zero
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wd_reset_flag <= 1'b0;
		else if (clk_en)
		begin
			if (timeout_hit && take_reset)
				wd_reset_flag <= 1'b1;
			else if (rst_wr && !reg_req.wdata[BIT_RESET_FLAG])
				wd_reset_flag <= 1'b0;
		end
	end

	// System reset request, one cycle per time-out that takes the reset action
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			sys_reset_req <= 1'b0;
		else if (clk_en)
			sys_reset_req <= timeout_hit & take_reset;
	end

	// Vector slots carried beside the requests
	assign wd_irq_vector    = '{number: WD_IRQ_VECTOR, address: WD_IRQ_ADDR};
	assign sys_reset_vector = '{number: SYS_RESET_VECTOR, address: SYS_RESET_ADDR};
	assign wd_irq_req       = wd_irq_flag & eff_irq_en;
	// Sticky event status, cleared by reading it; a new event wins
	assign evt_set = {timeout_hit & take_reset, timeout_hit & take_irq};
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			irq_status <= '0;
		else if (clk_en)
			irq_status <= (stat_rd ? '0 : irq_status) | evt_set;
	end

	// Interrupt mask
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			irq_mask <= MASK_RESET;
		else if (mask_wr)
			irq_mask <= reg_req.wdata[EVT_W-1:0];
	end
	assign irq = |(irq_status & irq_mask);

	// Read data stand for the one cycle after the read strobe
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (clk_en)
		begin
			reg_rdata <= 8'h00;
			if (reg_req.read)
			begin
				case (reg_req.addr)
					OFS_CONTROL:
						reg_rdata <= {wd_irq_flag, eff_irq_en, timeout_select[3],
							wd_change_enable, eff_reset_en, timeout_select[2:0]};
					OFS_RESET_STATUS:
						reg_rdata <= 8'(wd_reset_flag) << BIT_RESET_FLAG;
					OFS_IRQ_STATUS:
						reg_rdata <= {6'h00, irq_status};
					OFS_IRQ_MASK:
						reg_rdata <= {6'h00, irq_mask};
					default:
						reg_rdata <= 8'h00;
				endcase
			end
		end
	end
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_open;
		ctl_wr && reg_req.wdata[BIT_CHANGE_EN];
	endsequence
	sequence s_quiet;
		clk_en && !ctl_wr;
	endsequence
	property p_window_hold;
		s_open ##1 s_quiet [*3] |=> wd_change_enable;
	endproperty
	a_window_hold: assert property (p_window_hold) else $error("change window closed early");
	property p_window_close;
		s_open ##1 s_quiet [*4] |=> !wd_change_enable;
	endproperty
	a_window_close: assert property (p_window_close) else $error("change window not closed");
	property p_protect;
		ctl_wr && !wd_change_enable |=> timeout_select == $past(timeout_select)
			&& (wd_reset_enable || !$past(wd_reset_enable));
	endproperty
	a_protect: assert property (p_protect) else $error("protected field changed outside window");
	property p_flag_forces;
		ctl_rd && wd_reset_flag |=> reg_rdata[BIT_RESET_EN];
	endproperty
	a_flag_forces: assert property (p_flag_forces) else $error("reset enable not forced by flag");
	property p_field_map;
		ctl_rd |=> {reg_rdata[BIT_SEL3], reg_rdata[BIT_SEL2:BIT_SEL0]} == $past(timeout_select);
	endproperty
	a_field_map: assert property (p_field_map) else $error("select field misplaced");
	property p_reserved;
		timeout_select > MAX_SELECT |-> limit == (CNT_W'(TIMEOUT_BASE) << MAX_SELECT);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code not longest");
	property p_restart;
		clk_en && wd_restart |=> count == '0 ##1 (count <= CNT_W'(1));
	endproperty
	a_restart: assert property (p_restart) else $error("counter not restarted");
	property p_irq_set;
		timeout_hit && take_irq |=> wd_irq_flag && irq_status[EVT_IRQ] && !sys_reset_req;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("time-out interrupt lost");
	property p_fuse_reset;
		timeout_hit && fuse_s |=> sys_reset_req && wd_reset_flag ##1 !sys_reset_req;
	endproperty
	a_fuse_reset: assert property (p_fuse_reset) else $error("fuse time-out gave no reset");
	property p_ack_clear;
		clk_en && irq_vector_ack && !(timeout_hit && take_irq) |=> !wd_irq_flag && !wd_irq_req;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("flag survived vector");

endmodule // watchdog_timeout_control

/* test/test_watchdog_timeout_control.sv */
// Self-checking bench for the watchdog time-out control block
`timescale 1ns/100ps
`define CHK(act, exp, msg) begin comparisons++; if ((act) !== (exp)) begin errors++; \
	$display("CHECK FAILED t=%0t %s", $time, msg); end end
module test_watchdog_timeout_control
	import wd_pkg::*;
;
	// Stimulus and observed signals
	logic     clk;
	logic     rst_b;
	logic     clk_en;
	reg_req_t reg_req;
	logic [7:0] reg_rdata;
	logic     wd_osc_clk;
	logic     always_on_fuse;
	logic     wd_restart;
	logic     irq_vector_ack;
	logic     wd_irq_req;
	vector_t  wd_irq_vector;
	logic     sys_reset_req;
	vector_t  sys_reset_vector;
	logic     irq;
	int       errors;
	int       comparisons;
	int       n;
	logic [7:0] pend_exp;

	// Short base count keeps the longest time-out near 20k clocks
	watchdog_timeout_control #(.TIMEOUT_BASE(4)) u_dut (
		.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.wd_osc_clk(wd_osc_clk), .always_on_fuse(always_on_fuse), .wd_restart(wd_restart),
		.irq_vector_ack(irq_vector_ack), .wd_irq_req(wd_irq_req), .wd_irq_vector(wd_irq_vector),
		.sys_reset_req(sys_reset_req), .sys_reset_vector(sys_reset_vector), .irq(irq)
	);

	// 250 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Slow oscillator, ten system clocks a period, phase unrelated
	initial
	begin
		wd_osc_clk = 1'b0;
		#7;
		forever #20 wd_osc_clk = ~wd_osc_clk;
	end

	// One bus cycle; read data of the previous cycle is checked, zero when no read was made
	task automatic step(input logic w, r, input logic [3:0] a, input logic [7:0] d, e, input logic k, ack);
		@(posedge clk);
		reg_req <= '{write: w, read: r, addr: a, wdata: d};
		wd_restart <= k;
		irq_vector_ack <= ack;
		#1;
		`CHK(reg_rdata, pend_exp, "read data")
		pend_exp = r ? e : 8'h00;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		step(1'b1, 1'b0, a, d, 8'h00, 1'b0, 1'b0);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		step(1'b0, 1'b1, a, 8'h00, e, 1'b0, 1'b0);
	endtask

	task automatic idle(input int c);
		repeat (c) step(1'b0, 1'b0, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0);
	endtask

	task automatic kick();
		step(1'b0, 1'b0, 4'h0, 8'h00, 8'h00, 1'b1, 1'b0);
	endtask

	// Bounded wait for the interrupt request (rs=0) or the reset pulse (rs=1)
	task automatic wait_ev(input bit rs, input int lim, output int c);
		c = 0;
		while (((rs ? sys_reset_req : wd_irq_req) !== 1'b1) && c < lim)
		begin
			idle(1);
			c++;
		end
		if (c >= lim)
		begin
			errors++;
			$display("CHECK FAILED t=%0t no time-out seen", $time);
			close_out();
		end
	endtask

	// Interrupt mode at one select code; time-out measured from a restart
	task automatic meas(input logic [3:0] sel, input int ticks);
		wr(OFS_CONTROL, 8'h18);
		wr(OFS_CONTROL, {2'b11, sel[3], 2'b00, sel[2:0]});
		idle(15);
		kick();
		wait_ev(1'b0, ticks * 10 + 40, n);
		`CHK(n >= (ticks - 1) * 10 && n <= ticks * 10 + 8, 1'b1, "time-out length")
		`CHK(irq, 1'b1, "masked irq")
		rd(OFS_IRQ_STATUS, 8'h01);
		idle(1);
		`CHK(irq, 1'b0, "irq after status read")
		$display("test select %0d done", sel);
	endtask

	task automatic close_out();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		always_on_fuse = 1'b0;
		wd_restart = 1'b0;
		irq_vector_ack = 1'b0;
		reg_req = '0;
		errors = 0;
		comparisons = 0;
		pend_exp = 8'h00;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values, unmapped offset, vector slots
		rd(OFS_CONTROL, 8'h00);
		rd(OFS_IRQ_MASK, 8'h00);
		wr(4'h7, 8'hff);
		rd(4'h7, 8'h00);
		`CHK(wd_irq_vector, 22'({6'h0d, 16'h0018}), "irq vector")
		`CHK(sys_reset_vector, 22'({6'h01, 16'h0000}), "reset vector")
		$display("test reset done");
		// Window: open in cycles 1..4, shut in cycle 5, then a refused write
		wr(OFS_CONTROL, 8'h18);
		idle(3);
		rd(OFS_CONTROL, 8'h18);
		rd(OFS_CONTROL, 8'h08);
		wr(OFS_CONTROL, 8'h00);
		rd(OFS_CONTROL, 8'h08);
		wr(OFS_CONTROL, 8'h18);
		wr(OFS_CONTROL, 8'h21);
		rd(OFS_CONTROL, 8'h21);
		wr(OFS_CONTROL, 8'h00);
		rd(OFS_CONTROL, 8'h21);
		$display("test window done");
		// Time-out lengths, reserved code acting as the longest
		wr(OFS_IRQ_MASK, 8'h01);
		rd(OFS_IRQ_MASK, 8'h01);
		meas(4'h0, 4);
		meas(4'h1, 8);
		meas(4'h2, 16);
		meas(4'ha, 2048);
		// Interrupt then reset; vector execution drops to reset mode
		wr(OFS_CONTROL, 8'h18);
		wr(OFS_CONTROL, 8'hc8);
		kick();
		wait_ev(1'b0, 100, n);
		step(1'b0, 1'b0, 4'h0, 8'h00, 8'h00, 1'b0, 1'b1);
		rd(OFS_CONTROL, 8'h08);
		wait_ev(1'b1, 100, n);
		rd(OFS_RESET_STATUS, 8'h08);
		rd(OFS_IRQ_STATUS, 8'h03);
		$display("test irq reset done");
		// Reset flag holds the reset enable until it is cleared
		kick();
		wr(OFS_CONTROL, 8'h18);
		wr(OFS_CONTROL, 8'h00);
		rd(OFS_CONTROL, 8'h08);
		wr(OFS_RESET_STATUS, 8'h00);
		rd(OFS_RESET_STATUS, 8'h00);
		wr(OFS_CONTROL, 8'h18);
		wr(OFS_CONTROL, 8'h00);
		rd(OFS_CONTROL, 8'h00);
		$display("test reset flag done");
		// Freeze: the open window must survive a low enable, and a held write is dropped
		wr(OFS_CONTROL, 8'h18);
		@(posedge clk);
		clk_en <= 1'b0;
		wr(OFS_CONTROL, 8'h00);
		idle(6);
		@(posedge clk);
		clk_en <= 1'b1;
		rd(OFS_CONTROL, 8'h18);
		wr(OFS_CONTROL, 8'h00);
		rd(OFS_CONTROL, 8'h00);
		idle(1);
		$display("test freeze done");
		// Fuse forces reset mode with both enables clear
		@(posedge clk);
		always_on_fuse <= 1'b1;
		idle(4);
		rd(OFS_CONTROL, 8'h08);
		kick();
		wait_ev(1'b1, 100, n);
		$display("test fuse done");
		close_out();
	end
endmodule // test_watchdog_timeout_control
